/* File: hw/hbd_debounce.sv */
/*
 * One debounce channel: the input must hold the same level on eight
 * consecutive sampling ticks before the output follows it.
 * Assumes the tick is a one-cycle enable from the main divider.
 */
`timescale 1ns/1ps
module hbd_debounce (
    input  wire logic core_clk_in,   // Core clock
    input  wire logic rst_n_in,      // Synchronous reset, low
    input  wire logic clr_in,        // Hold output low, restart
    input  wire logic bypass_in,     // No debounce: follow input
    input  wire logic tick_in,       // Sampling tick
    input  wire logic raw_in,        // Raw level
    output logic      level_out      // Debounced level
);
    typedef struct packed {
        logic       lvl;     // Accepted level
        logic       cand;    // Candidate level
        logic [3:0] cnt;     // Stable tick count
    } hbd_db_s;
    hbd_db_s st_q, st_d;

    // Next state: count stable ticks, accept after full period
    always_comb begin
        st_d = st_q;
        if (clr_in) begin
            st_d = '0;
        end else if (bypass_in) begin
            st_d.lvl  = raw_in;
            st_d.cand = raw_in;
            st_d.cnt  = '0;
        end else if (tick_in) begin
            if (raw_in != st_d.cand) begin
                // Level moved: restart period
                st_d.cand = raw_in;
                st_d.cnt  = 4'h1;
            end else if (st_q.cnt < hbd_pkg::HBD_DB_TICKS) begin
                st_d.cnt = st_q.cnt + 4'h1;
            end
            if (st_d.cnt == hbd_pkg::HBD_DB_TICKS) begin
                st_d.lvl = st_d.cand;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_out = st_q.lvl;

    // Output changes only at a tick once eight stable ticks seen
    stable_accept_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        ($changed(st_q.lvl) && !$past(clr_in) && !$past(bypass_in)) |->
        $past(tick_in) && st_q.cnt == hbd_pkg::HBD_DB_TICKS)
        else $error("debounced level moved without a full stable period");
endmodule

/* File: hw/hbd_pkg.sv */
/*
 * Constants shared by the headset and button detection block: register
 * offsets, field positions, reset values and debounce timing.
 * Assumes a 50 MHz core clock and an 8-bit register port.
 */
// Contract
// - Detection runs only while enable bit set
// - Type field: 00 none, 01 plain, 11 mic
// - Jack debounce 16..512 ms on 2..64 ms ticks
// - Button debounce 0, 8, 16, 32 ms
// - Coupling bit picks capless or ac-coupled drivers
// - Bit D6 selects fully differential stereo output
// - Bit D3 selects pseudodifferential stereo output
// - Sticky button flag set on debounced press
// - Reading register B clears button flag
// - Live headset flag, not sticky
// - Register B low three bits read zero
package hbd_pkg;
    // Register offsets
    localparam logic [7:0] HBD_OFS_CTRL_A   = 8'h0d;
    localparam logic [7:0] HBD_OFS_CTRL_B   = 8'h0e;
    // Register A fields
    localparam int         HBD_A_EN_BIT     = 7;
    localparam int         HBD_A_TYPE_LO    = 5;
    localparam int         HBD_A_JDB_LO     = 2;
    localparam int         HBD_A_BDB_LO     = 0;
    // Register B fields
    localparam int         HBD_B_ACC_BIT    = 7;
    localparam int         HBD_B_FDIF_BIT   = 6;
    localparam int         HBD_B_BTN_BIT    = 5;
    localparam int         HBD_B_HS_BIT     = 4;
    localparam int         HBD_B_PDIF_BIT   = 3;
    // Reset values
    localparam logic [7:0] HBD_RST_BYTE     = 8'h00;
    // Headset type codes
    localparam logic [1:0] HBD_TYPE_NONE    = 2'h0;
    localparam logic [1:0] HBD_TYPE_NOMIC   = 2'h1;
    localparam logic [1:0] HBD_TYPE_MIC     = 2'h3;
    // Debounce: every period is eight ticks; tick = 1 ms << shift
    localparam logic [3:0] HBD_DB_TICKS     = 4'h8;
    localparam int         HBD_CLK_HZ       = 50000000;
    localparam int         HBD_BASE_TICK_MS = 1;
    localparam int         HBD_MS_CYCLES    = HBD_CLK_HZ / 1000 * HBD_BASE_TICK_MS;
    localparam logic [5:0] HBD_MAX_DIV      = 6'h3f;
    localparam logic [2:0] HBD_JDB_MAXCODE  = 3'h5;
endpackage

/* File: hw/hbd_top.sv */
/*
 * Headset jack and button press detection with output driver
 * configuration bits. Two byte registers on a plain strobe port.
 * Assumes jack and button inputs synchronous to core_clk_in.
 */
`timescale 1ns/1ps
module hbd_top #(
    parameter int CYCLES_PER_MS = hbd_pkg::HBD_MS_CYCLES  // Core cycles in one millisecond
) (
    input  wire logic       core_clk_in,      // 50 MHz core clock
    input  wire logic       rst_n_in,         // Synchronous reset, low
    input  wire logic [7:0] addr_in,          // Register address
    input  wire logic [7:0] wdata_in,         // Write data
    input  wire logic       wr_in,            // Write strobe
    input  wire logic       rd_in,            // Read strobe
    output logic      [7:0] rdata_out,        // Read data, next cycle
    input  wire logic       jack_in,          // Jack inserted level
    input  wire logic       mic_in,           // Microphone present level
    input  wire logic       button_in,        // Button pressed level
    output logic            ac_coupled_out,   // High-power ac-coupled mode
    output logic            fully_diff_out,   // Fully differential stereo
    output logic            pseudo_diff_out   // Pseudodifferential stereo
);
    typedef struct packed {
        logic       en;        // Detection enable
        logic [2:0] jdb;       // Jack debounce code
        logic [1:0] bdb;       // Button debounce code
        logic       acc;       // Coupling
        logic       fdif;      // Fully differential
        logic       pdif;      // Pseudodifferential
        logic       btn_flag;  // Sticky press flag
        logic       btn_prev;  // Last debounced button
        logic [5:0] ms_div;    // Millisecond counter
        logic [15:0] cyc;      // Cycles within a millisecond
        logic [7:0] rdata;     // Read data register
    } hbd_top_s;
    hbd_top_s st_q, st_d;

    logic       ms_tick;      // One-cycle 1 ms pulse
    logic       jack_tick;    // Jack sampling tick
    logic       btn_tick;     // Button sampling tick
    logic       jack_db;      // Debounced jack
    logic       mic_db;       // Debounced microphone
    logic       btn_db;       // Debounced button
    logic [1:0] hs_type;      // Reported accessory type
    logic [5:0] jmask;        // Jack tick divide mask
    logic [5:0] bmask;        // Button tick divide mask
    logic       rd_b;         // Read of register B

    // Millisecond enable from the cycle counter
    assign ms_tick = (st_q.cyc == 16'(CYCLES_PER_MS - 1));

    // Jack tick 2..64 ms: mask of (2 << code) - 1
    assign jmask     = 6'((7'h2 << st_q.jdb) - 7'h1);
    assign jack_tick = ms_tick && ((st_q.ms_div & jmask) == jmask);
    // Button tick 1, 2, 4 ms for codes 01, 10, 11
    assign bmask    = (st_q.bdb == 2'h3) ? 6'h3 : ((st_q.bdb == 2'h2) ? 6'h1 : 6'h0);
    assign btn_tick = ms_tick && ((st_q.ms_div & bmask) == bmask);

    // Jack and microphone channels share the jack period
    hbd_debounce u_jack (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .clr_in      (!st_q.en),
        .bypass_in   (1'b0),
        .tick_in     (jack_tick),
        .raw_in      (jack_in),
        .level_out   (jack_db)
    );
    hbd_debounce u_mic (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .clr_in      (!st_q.en),
        .bypass_in   (1'b0),
        .tick_in     (jack_tick),
        .raw_in      (mic_in),
        .level_out   (mic_db)
    );
    // Button channel; code 00 passes the input straight through
    hbd_debounce u_btn (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .clr_in      (!st_q.en || !jack_db),
        .bypass_in   (st_q.bdb == 2'h0),
        .tick_in     (btn_tick),
        .raw_in      (button_in),
        .level_out   (btn_db)
    );

    // Accessory type; 10 is never produced
    always_comb begin
        if (!jack_db) begin
            hs_type = hbd_pkg::HBD_TYPE_NONE;
        end else if (mic_db) begin
            hs_type = hbd_pkg::HBD_TYPE_MIC;
        end else begin
            hs_type = hbd_pkg::HBD_TYPE_NOMIC;
        end
    end

    assign rd_b = rd_in && (addr_in == hbd_pkg::HBD_OFS_CTRL_B);

    // Next state: dividers, register writes, reads and flag
    always_comb begin
        st_d = st_q;
        // Divider runs always
        if (ms_tick) begin
            st_d.cyc    = '0;
            st_d.ms_div = st_q.ms_div + 6'h1;
        end else begin
            st_d.cyc = st_q.cyc + 16'h1;
        end
        // Register writes
        if (wr_in && addr_in == hbd_pkg::HBD_OFS_CTRL_A) begin
            st_d.en  = wdata_in[hbd_pkg::HBD_A_EN_BIT];
            st_d.jdb = wdata_in[hbd_pkg::HBD_A_JDB_LO +: 3];
            st_d.bdb = wdata_in[hbd_pkg::HBD_A_BDB_LO +: 2];
        end
        if (wr_in && addr_in == hbd_pkg::HBD_OFS_CTRL_B) begin
            st_d.acc  = wdata_in[hbd_pkg::HBD_B_ACC_BIT];
            st_d.fdif = wdata_in[hbd_pkg::HBD_B_FDIF_BIT];
            st_d.pdif = wdata_in[hbd_pkg::HBD_B_PDIF_BIT];
        end
        // Read data, registered one cycle
        st_d.rdata = hbd_pkg::HBD_RST_BYTE;
        if (rd_in && addr_in == hbd_pkg::HBD_OFS_CTRL_A) begin
            st_d.rdata[hbd_pkg::HBD_A_EN_BIT]       = st_q.en;
            st_d.rdata[hbd_pkg::HBD_A_TYPE_LO +: 2] = hs_type;
            st_d.rdata[hbd_pkg::HBD_A_JDB_LO +: 3]  = st_q.jdb;
            st_d.rdata[hbd_pkg::HBD_A_BDB_LO +: 2]  = st_q.bdb;
        end else if (rd_b) begin
            st_d.rdata[hbd_pkg::HBD_B_ACC_BIT]  = st_q.acc;
            st_d.rdata[hbd_pkg::HBD_B_FDIF_BIT] = st_q.fdif;
            st_d.rdata[hbd_pkg::HBD_B_BTN_BIT]  = st_q.btn_flag;
            st_d.rdata[hbd_pkg::HBD_B_HS_BIT]   = jack_db;
            st_d.rdata[hbd_pkg::HBD_B_PDIF_BIT] = st_q.pdif;  // low bits stay zero
        end
        // Sticky flag: clear on read, a new press wins
        st_d.btn_prev = btn_db;
        if (rd_b) begin
            st_d.btn_flag = 1'b0;
        end
        if (btn_db && !st_q.btn_prev) begin
            st_d.btn_flag = 1'b1;
        end
    end

    // State register
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs
    assign rdata_out       = st_q.rdata;
    assign ac_coupled_out  = st_q.acc;
    assign fully_diff_out  = st_q.fdif;
    assign pseudo_diff_out = st_q.pdif;

    sequence press_rise_s;
        btn_db && !st_q.btn_prev;
    endsequence

    // Press edge always sets the flag next cycle
    flag_set_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        press_rise_s |=> st_q.btn_flag)
        else $error("button flag not set after press");
    // Read without new press clears flag
    flag_clear_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (rd_b && !(btn_db && !st_q.btn_prev)) |=> !st_q.btn_flag)
        else $error("button flag not cleared by read");
    // Disabled detection shows no headset
    detect_off_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !st_q.en |=> ##1 !jack_db)
        else $error("headset seen while detection disabled");
    // Type never reads reserved code
    type_code_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        rd_in && addr_in == hbd_pkg::HBD_OFS_CTRL_A |=> rdata_out[6:5] != 2'h2)
        else $error("reserved headset type reported");
    // Reserved bits read zero
    resv_zero_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        rd_b |=> rdata_out[2:0] == 3'h0)
        else $error("reserved bits not zero");
    // Live headset flag matches debounced jack
    live_flag_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        rd_b |=> rdata_out[4] == $past(jack_db))
        else $error("headset flag wrong");
    // Coupling follows the written bit
    coupling_wr_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        wr_in && addr_in == hbd_pkg::HBD_OFS_CTRL_B |=> ac_coupled_out == $past(wdata_in[7]))
        else $error("coupling bit not stored");
    // Stereo selections follow the written bits
    stereo_cfg_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        wr_in && addr_in == hbd_pkg::HBD_OFS_CTRL_B |=>
        fully_diff_out == $past(wdata_in[6]) && pseudo_diff_out == $past(wdata_in[3]))
        else $error("stereo configuration not stored");
    // Jack ticks come only on millisecond ticks
    jack_tick_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        jack_tick |-> ms_tick && st_q.ms_div[0])
        else $error("jack tick off the 2 ms grid");
    // Button tick at 1 ms granularity
    btn_tick_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        btn_tick |-> ms_tick)
        else $error("button tick off the millisecond grid");

    // Register A write cycle
    sequence wr_a_s;
        wr_in && addr_in == hbd_pkg::HBD_OFS_CTRL_A;
    endsequence
    // Register A read cycle
    sequence rd_a_s;
        rd_in && addr_in == hbd_pkg::HBD_OFS_CTRL_A;
    endsequence

    // Enable bit stored from a write
    en_store_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        wr_a_s |=> st_q.en == $past(wdata_in[hbd_pkg::HBD_A_EN_BIT]))
        else $error("enable bit not stored");
    // Jack debounce code stored from a write
    jdb_store_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        wr_a_s |=> st_q.jdb == $past(wdata_in[hbd_pkg::HBD_A_JDB_LO +: 3]))
        else $error("jack debounce code not stored");
    // Button debounce code stored from a write
    bdb_store_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        wr_a_s |=> st_q.bdb == $past(wdata_in[hbd_pkg::HBD_A_BDB_LO +: 2]))
        else $error("button debounce code not stored");
    // Enable bit read back
    en_readback_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        rd_a_s |=> rdata_out[hbd_pkg::HBD_A_EN_BIT] == $past(st_q.en))
        else $error("enable bit read back wrong");
    // Jack debounce code read back
    jdb_readback_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        rd_a_s |=> rdata_out[hbd_pkg::HBD_A_JDB_LO +: 3] == $past(st_q.jdb))
        else $error("jack debounce code read back wrong");
    // Button debounce code read back
    bdb_readback_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        rd_a_s |=> rdata_out[hbd_pkg::HBD_A_BDB_LO +: 2] == $past(st_q.bdb))
        else $error("button debounce code read back wrong");
    // No jack reads as no headset
    type_none_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (rd_in && addr_in == hbd_pkg::HBD_OFS_CTRL_A && !jack_db) |=>
        rdata_out[hbd_pkg::HBD_A_TYPE_LO +: 2] == hbd_pkg::HBD_TYPE_NONE)
        else $error("type not none without jack");
    // Jack and mic read as headset with mic
    type_mic_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (rd_in && addr_in == hbd_pkg::HBD_OFS_CTRL_A && jack_db && mic_db) |=>
        rdata_out[hbd_pkg::HBD_A_TYPE_LO +: 2] == hbd_pkg::HBD_TYPE_MIC)
        else $error("type not mic headset");
    // Jack alone reads as headset without mic
    type_nomic_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (rd_in && addr_in == hbd_pkg::HBD_OFS_CTRL_A && jack_db && !mic_db) |=>
        rdata_out[hbd_pkg::HBD_A_TYPE_LO +: 2] == hbd_pkg::HBD_TYPE_NOMIC)
        else $error("type not plain headset");
    // Flag holds until a read
    flag_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (st_q.btn_flag && !rd_b) |=> st_q.btn_flag)
        else $error("button flag dropped without read");
    // Flag rises only after a press edge
    flag_cause_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        $rose(st_q.btn_flag) |-> $past(btn_db && !st_q.btn_prev))
        else $error("button flag set without press");
    // Flag read back on register B
    flag_readback_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        rd_b |=> rdata_out[hbd_pkg::HBD_B_BTN_BIT] == $past(st_q.btn_flag))
        else $error("button flag read back wrong");
    // Output configuration read back on register B
    cfg_readback_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        rd_b |=> rdata_out[hbd_pkg::HBD_B_ACC_BIT] == $past(st_q.acc) &&
        rdata_out[hbd_pkg::HBD_B_FDIF_BIT] == $past(st_q.fdif) &&
        rdata_out[hbd_pkg::HBD_B_PDIF_BIT] == $past(st_q.pdif))
        else $error("configuration read back wrong");
    // Code 00 follows the button in one cycle
    bypass_follow_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (st_q.en && jack_db && st_q.bdb == 2'h0) |=> btn_db == $past(button_in))
        else $error("unfiltered button not followed");
    // No button without a headset
    btn_gate_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !jack_db |=> !btn_db)
        else $error("button seen without headset");
    // Disabled detection clears the mic channel
    mic_off_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !st_q.en |=> !mic_db)
        else $error("mic seen while detection disabled");
    // Disabled detection clears the button channel
    btn_off_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !st_q.en |=> !btn_db)
        else $error("button seen while detection disabled");
    // Jack result moves only on a jack tick
    jack_change_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        ($changed(jack_db) && $past(st_q.en)) |-> $past(jack_tick))
        else $error("jack result moved off a tick");
    // Mic result moves only on a jack tick
    mic_change_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        ($changed(mic_db) && $past(st_q.en)) |-> $past(jack_tick))
        else $error("mic result moved off a tick");
    // Filtered button moves only on a button tick
    btn_change_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        ($changed(btn_db) && $past(st_q.en && jack_db && st_q.bdb != 2'h0)) |-> $past(btn_tick))
        else $error("button result moved off a tick");
    // Coupling holds without a register B write
    acc_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !(wr_in && addr_in == hbd_pkg::HBD_OFS_CTRL_B) |=> $stable(ac_coupled_out))
        else $error("coupling changed without write");
    // Stereo selections hold without a register B write
    stereo_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !(wr_in && addr_in == hbd_pkg::HBD_OFS_CTRL_B) |=>
        $stable(fully_diff_out) && $stable(pseudo_diff_out))
        else $error("stereo selection changed without write");
    // Millisecond counter restarts after its tick
    ms_period_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        ms_tick |=> st_q.cyc == 16'h0)
        else $error("millisecond counter not restarted");
    // Code 11 samples on the 4 ms grid
    btn_grid_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (btn_tick && st_q.bdb == 2'h3) |-> st_q.ms_div[1:0] == 2'h3)
        else $error("button tick off the 4 ms grid");
endmodule

/* File: verif/hbd_headset_model.sv */
/*
 * Behavioural headset at the jack: jack, mic and button contacts.
 * Assumes bench commands change just after a rising clock edge.
 */
`timescale 1ns/1ps
module hbd_headset_model (
    input  wire logic core_clk_in,  // Core clock
    input  wire logic plug_in,      // Headset inserted
    input  wire logic mic_fit_in,   // Headset carries a mic
    input  wire logic press_in,     // Button held down
    output logic      jack_out = 1'b0,   // Jack contact level, open at start
    output logic      mic_out = 1'b0,    // Mic contact level, open at start
    output logic      button_out = 1'b0  // Button contact level, open at start
);
    // Mic and button only close on a plugged headset
    always @(posedge core_clk_in) begin
        jack_out   <= plug_in;
        mic_out    <= plug_in & mic_fit_in;
        button_out <= plug_in & press_in;
    end
endmodule

/* File: verif/headset_button_detect_test.sv */
/*
 * Self-checking bench for the headset and button detection block.
 * Assumes the strobe register port and a 50 MHz clock; the design's
 * millisecond is shortened to 50 cycles so debounce runs stay short.
 */
`timescale 1ns/1ps
module headset_button_detect_test;
    localparam logic [7:0] REG_A = hbd_pkg::HBD_OFS_CTRL_A;  // Control A
    localparam logic [7:0] REG_B = hbd_pkg::HBD_OFS_CTRL_B;  // Control B
    localparam int         BENCH_MS = 50;                     // Cycles per millisecond
    logic       core_clk_in = 1'b0;  // Core clock
    logic       rst_n_in    = 1'b0;  // Reset, low
    logic [7:0] addr_in     = 8'h00; // Register address
    logic [7:0] wdata_in    = 8'h00; // Write data
    logic       wr_in       = 1'b0;  // Write strobe
    logic       rd_in       = 1'b0;  // Read strobe
    logic       plug        = 1'b0;  // Headset inserted
    logic       mic_fit     = 1'b0;  // Headset has mic
    logic       press       = 1'b0;  // Button held
    logic [7:0] rdata_out;           // Read data
    logic       jack_in;             // Jack level
    logic       mic_in;              // Mic level
    logic       button_in;           // Button level
    logic       ac_coupled_out;      // Coupling mode
    logic       fully_diff_out;      // Fully differential
    logic       pseudo_diff_out;     // Pseudodifferential
    logic [7:0] rd_val;              // Last read value
    logic [7:0] cfg [7];             // Config write values
    int         errors       = 0;    // Mismatch count
    int         total_checks = 0;    // Comparison count

    // Clock, 20 ns period
    always #10 core_clk_in = ~core_clk_in;

    hbd_top #(.CYCLES_PER_MS(BENCH_MS)) i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .jack_in(jack_in), .mic_in(mic_in),
        .button_in(button_in), .ac_coupled_out(ac_coupled_out), .fully_diff_out(fully_diff_out),
        .pseudo_diff_out(pseudo_diff_out));

    hbd_headset_model i_headset (.core_clk_in(core_clk_in), .plug_in(plug), .mic_fit_in(mic_fit),
        .press_in(press), .jack_out(jack_in), .mic_out(mic_in), .button_out(button_in));

    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask

    // One-cycle write
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge core_clk_in);
        wr_in    <= 1'b0;
    endtask

    // One-cycle read, data taken in the following cycle
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge core_clk_in);
        rd_in   <= 1'b0;
        #1 d = rdata_out;
    endtask

    // Read and compare
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        reg_rd(a, d);
        chk(d, exp, what);
    endtask

    // Verdict and end of run
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Hang guard, well past the detection run
    initial begin
        #200000;
        errors++;
        $display("Error at %0t: watchdog expired", $time);
        wrap_up();
    end

    // Test sequence
    initial begin
        cfg = '{8'h80, 8'h40, 8'h08, 8'h88, 8'hc0, 8'hb0, 8'h00};
        repeat (10) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        rd_chk(REG_A, 8'h00, "reset A");
        rd_chk(REG_B, 8'h00, "reset B");
        rd_chk(8'h0f, 8'h00, "unmapped read");
        $display("Test reset values done");
        // Every legal debounce code pair, detection off
        for (int j = 0; j <= 5; j++) begin
            for (int b = 0; b <= 3; b++) begin
                reg_wr(REG_A, {3'h0, j[2:0], b[1:0]});
                rd_chk(REG_A, {3'h0, j[2:0], b[1:0]}, "debounce codes");
            end
        end
        reg_wr(REG_A, 8'h60);
        rd_chk(REG_A, 8'h00, "type read only");
        $display("Test debounce codes done");
        // Output configuration, never both stereo bits, low bits zero
        for (int i = 0; i < 7; i++) begin
            reg_wr(REG_B, cfg[i]);
            #1 chk({5'h0, ac_coupled_out, fully_diff_out, pseudo_diff_out},
                   {5'h0, cfg[i][7], cfg[i][6], cfg[i][3]}, "config pins");
            rd_chk(REG_B, cfg[i] & 8'hc8, "config readback");
        end
        $display("Test output configuration done");
        // Jack with mic, 16 ms debounce, button unfiltered
        reg_wr(REG_B, 8'h80);
        reg_wr(REG_A, 8'h80);
        plug    <= 1'b1;
        mic_fit <= 1'b1;
        repeat (12 * BENCH_MS) @(posedge core_clk_in);
        rd_chk(REG_B, 8'h80, "early headset flag");
        rd_val = 8'h00;
        for (int n = 0; n < 300 && rd_val[4] !== 1'b1; n++) begin
            repeat (10) @(posedge core_clk_in);
            reg_rd(REG_B, rd_val);
        end
        chk(rd_val, 8'h90, "headset flag");
        rd_chk(REG_A, 8'he0, "type with mic");
        $display("Test jack detection done");
        // Short press then release
        @(posedge core_clk_in);
        press <= 1'b1;
        repeat (5) @(posedge core_clk_in);
        press <= 1'b0;
        repeat (5) @(posedge core_clk_in);
        rd_chk(REG_B, 8'hb0, "sticky button");
        rd_chk(REG_B, 8'h90, "button cleared");
        $display("Test button flag done");
        // Button debounce 8 ms on 1 ms ticks
        reg_wr(REG_A, 8'h81);
        rd_chk(REG_A, 8'he1, "button code stored");
        press <= 1'b1;
        repeat (4 * BENCH_MS) @(posedge core_clk_in);
        press <= 1'b0;
        repeat (5) @(posedge core_clk_in);
        rd_chk(REG_B, 8'h90, "short press filtered");
        press <= 1'b1;
        repeat (10 * BENCH_MS) @(posedge core_clk_in);
        rd_chk(REG_B, 8'hb0, "filtered press");
        press <= 1'b0;
        $display("Test button debounce done");
        // Detection off drops live results
        reg_wr(REG_A, 8'h00);
        repeat (3) @(posedge core_clk_in);
        rd_chk(REG_B, 8'h80, "disabled flag");
        rd_chk(REG_A, 8'h00, "disabled type");
        $display("Test disable done");
        wrap_up();
    end
endmodule
